// >>> rsc_regs.vh
// register map, field positions, reset values and timing constants
`ifndef RSC_REGS_VH
`define RSC_REGS_VH

`define RSC_ADDR_W 12
`define RSC_OFF_STATUS0 12'h000
`define RSC_OFF_STATUS1 12'h004
`define RSC_OFF_CONFIG 12'h008
`define RSC_OFF_CAUSE 12'h00c

// reset_status_0 fields
`define RSC_S0_POR 0
`define RSC_S0_MON0 1
`define RSC_S0_MON1 2
`define RSC_S0_MON2 3
`define RSC_S0_DSBY 4
`define RSC_S0_BATT 5
// reset_status_1 fields
`define RSC_S1_INDEPENDENT_WATCHDOG 0
`define RSC_S1_WWDT 1
`define RSC_S1_SW 2
`define RSC_S1_PAR 3
`define RSC_S1_ECC 4
`define RSC_S1_BMPU 5
`define RSC_S1_SMPU 6
`define RSC_S1_SP 7
`define RSC_S1_SEC 8
`define RSC_S1_CPAR 9
// config fields
`define RSC_CF_MON0 0
`define RSC_CF_MON1 1
`define RSC_CF_MON2 2
`define RSC_CF_INDEPENDENT_WATCHDOG_NMI 3
`define RSC_CF_WWDT_NMI 4
`define RSC_CF_BATT_EN 5
`define RSC_CF_W 6
`define RSC_CF_RESET 6'h00

// variants
`define RSC_VAR_A 1'b0
`define RSC_VAR_B 1'b1

// timing in ns at 200 MHz (period 5 ns), except the deep standby hold, which is in cycles
`define RSC_CLK_NS 5
`define RSC_POR_NS 1000000
`define RSC_WDT_NS 200
`define RSC_SW_NS 300
`define RSC_MON_NS 10000
`define RSC_DSBY_CYC 35
`define RSC_CNT_W 20

`endif

// >>> rsc_stretch.v
// hold-off counter: output stays high while the request is high and
// for a fixed count of cycles after it falls
`timescale 1ns/1ps
`default_nettype none
module rsc_stretch #(
  parameter CNT_W = 20,
  parameter [CNT_W-1:0] HOLD = 1
) (
  input wire clk_i,
  input wire arst_n_i,
  input wire req_i,
  output wire active_o
);
  reg [CNT_W-1:0] cnt;
  reg busy;
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt <= {CNT_W{1'b0}};
      busy <= 1'b1;
    end else if (req_i) begin
      cnt <= HOLD;
      busy <= 1'b1;
    end else if (cnt != {CNT_W{1'b0}}) begin
      cnt <= cnt - {{(CNT_W-1){1'b0}}, 1'b1};
      busy <= 1'b1;
    end else begin
      busy <= 1'b0;
    end
  end
  assign active_o = busy;
endmodule // rsc_stretch
`default_nettype wire

// >>> rsc_ctrl.v
// reset source controller: gathers reset sources, drives internal reset
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "rsc_regs.vh"
`default_nettype none
module rsc_ctrl #(
  parameter VARIANT = 0,
  parameter HAS_CACHE_PAR = 1,
  parameter [`RSC_CNT_W-1:0] POR_CYC = `RSC_POR_NS / `RSC_CLK_NS
) (
  input wire clk_i,
  input wire arst_n_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [`RSC_ADDR_W-1:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [3:0] pstrb_i,
  output wire [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  input wire ext_reset_pin_n_i,
  input wire supply_above_por_i,
  input wire supply_below_batt_i,
  input wire [2:0] supply_below_mon_i,
  input wire indep_watchdog_underflow_i,
  input wire indep_watchdog_refresh_miss_i,
  input wire window_watchdog_underflow_i,
  input wire window_watchdog_refresh_miss_i,
  input wire sram_parity_err_i,
  input wire sram_ecc_err_i,
  input wire master_prot_err_i,
  input wire slave_prot_err_i,
  input wire stack_ptr_err_i,
  input wire security_err_i,
  input wire cache_parity_err_i,
  input wire deep_standby_wake_i,
  input wire core_sys_reset_request_i,
  output reg internal_reset_n_o,
  output reg nmi_o,
  output reg backup_on_battery_o
);
  localparam [`RSC_CNT_W-1:0] WDT_CYC =
    (`RSC_WDT_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS;
  localparam [`RSC_CNT_W-1:0] SW_CYC =
    (`RSC_SW_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS;
  localparam [`RSC_CNT_W-1:0] MON_CYC =
    (`RSC_MON_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS;
  localparam [`RSC_CNT_W-1:0] DSBY_CYC = `RSC_DSBY_CYC;
  localparam [0:0] VA = (VARIANT == 0);

  // reset domain states
  localparam [2:0] ST_POR = 3'b001;
  localparam [2:0] ST_HOLD = 3'b010;
  localparam [2:0] ST_RUN = 3'b100;

  // all pins and foreign-domain detectors pass two flops
  localparam NIN = 19;
  wire [NIN-1:0] raw = {cache_parity_err_i, security_err_i,
    stack_ptr_err_i, slave_prot_err_i, master_prot_err_i,
    sram_ecc_err_i, sram_parity_err_i, window_watchdog_refresh_miss_i,
    window_watchdog_underflow_i, indep_watchdog_refresh_miss_i,
    indep_watchdog_underflow_i, supply_below_mon_i, supply_below_batt_i,
    supply_above_por_i, ext_reset_pin_n_i, deep_standby_wake_i,
    core_sys_reset_request_i};
  reg [NIN-1:0] sync_a;
  reg [NIN-1:0] sync_b;
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync_a <= {NIN{1'b0}};
      sync_b <= {NIN{1'b0}};
    end else begin
      sync_a <= raw;
      sync_b <= sync_a;
    end
  end
  wire s_swreq = sync_b[0];
  wire s_dsby = sync_b[1];
  wire s_pin_n = sync_b[2];
  wire s_por_ok = sync_b[3];
  wire s_batt = sync_b[4];
  wire [2:0] s_mon = sync_b[7:5];
  wire s_independent_watchdog = sync_b[8] | sync_b[9];
  wire s_wwdt = sync_b[10] | sync_b[11];
  wire s_par = sync_b[12];
  wire s_ecc = sync_b[13];
  wire s_bmpu = sync_b[14];
  wire s_smpu = sync_b[15];
  wire s_sp = sync_b[16];
  wire s_sec = sync_b[17];
  wire s_cpar = sync_b[18];

  // named cfg: the plain word is a reserved keyword of the language
  reg [`RSC_CF_W-1:0] cfg;
  reg [5:0] status0;
  reg [9:0] status1;
  reg [2:0] state;
  reg [`RSC_CNT_W-1:0] por_cnt;
  reg swreq_d;
  reg dsby_d;

  // power-on: pin high while supply below threshold, then timed release
  wire por_cond = s_pin_n & ~s_por_ok;
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= ST_POR;
      por_cnt <= {`RSC_CNT_W{1'b0}};
    end else begin
      case (state)
        ST_POR: begin
          if (!s_por_ok) begin
            por_cnt <= POR_CYC;
          end else if (por_cnt != {`RSC_CNT_W{1'b0}}) begin
            por_cnt <= por_cnt - {{(`RSC_CNT_W-1){1'b0}}, 1'b1};
          end else begin
            state <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (por_cond) begin
            state <= ST_POR;
            por_cnt <= POR_CYC;
          end else begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (por_cond) begin
            state <= ST_POR;
            por_cnt <= POR_CYC;
          end
        end
        default: begin
          state <= ST_POR;
        end
      endcase
    end
  end
  wire in_por = (state == ST_POR);

  // event edges for one-shot requests
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      swreq_d <= 1'b0;
      dsby_d <= 1'b0;
    end else begin
      swreq_d <= s_swreq;
      dsby_d <= s_dsby;
    end
  end

  // enabled reset requests per source
  wire [2:0] mon_req = s_mon & cfg[`RSC_CF_MON2:`RSC_CF_MON0];
  wire independent_watchdog_rst = s_independent_watchdog & ~cfg[`RSC_CF_INDEPENDENT_WATCHDOG_NMI];
  wire wwdt_rst = s_wwdt & ~cfg[`RSC_CF_WWDT_NMI];
  wire batt_req = VA & s_batt & cfg[`RSC_CF_BATT_EN];
  wire smpu_req = VA & s_smpu;
  wire sp_req = VA & s_sp;
  wire sec_req = ~VA & s_sec;
  wire cpar_req = ~VA & (HAS_CACHE_PAR != 0) & s_cpar;
  wire dsby_req = ~VA & s_dsby & ~dsby_d;
  wire sw_req = s_swreq & ~swreq_d;
  wire err_req = s_par | s_ecc | s_bmpu | smpu_req | sp_req | sec_req |
    cpar_req;

  wire independent_watchdog_act;
  wire wwdt_act;
  wire sw_act;
  wire dsby_act;
  wire mon_act;
  rsc_stretch #(.CNT_W(`RSC_CNT_W), .HOLD(WDT_CYC)) u_independent_watchdog (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .req_i(independent_watchdog_rst),
    .active_o(independent_watchdog_act));
  rsc_stretch #(.CNT_W(`RSC_CNT_W), .HOLD(WDT_CYC)) u_wwdt (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .req_i(wwdt_rst),
    .active_o(wwdt_act));
  rsc_stretch #(.CNT_W(`RSC_CNT_W), .HOLD(SW_CYC)) u_sw (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .req_i(sw_req),
    .active_o(sw_act));
  rsc_stretch #(.CNT_W(`RSC_CNT_W), .HOLD(DSBY_CYC)) u_dsby (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .req_i(dsby_req),
    .active_o(dsby_act));
  rsc_stretch #(.CNT_W(`RSC_CNT_W), .HOLD(MON_CYC)) u_mon (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .req_i(|mon_req),
    .active_o(mon_act));

  // internal reset: any source holds it, release on a clock edge
  wire any_src = in_por | ~s_pin_n | independent_watchdog_act | wwdt_act | sw_act |
    dsby_act | mon_act | batt_req | err_req;
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      internal_reset_n_o <= 1'b0;
      nmi_o <= 1'b0;
      backup_on_battery_o <= 1'b0;
    end else begin
      internal_reset_n_o <= ~any_src;
      nmi_o <= (s_independent_watchdog & cfg[`RSC_CF_INDEPENDENT_WATCHDOG_NMI]) |
        (s_wwdt & cfg[`RSC_CF_WWDT_NMI]);
      backup_on_battery_o <= s_batt;
    end
  end

  // apb slave, zero wait states
  wire acc = psel_i & penable_i;
  wire wr = acc & pwrite_i;
  wire hit_s0 = (paddr_i == `RSC_OFF_STATUS0);
  wire hit_s1 = (paddr_i == `RSC_OFF_STATUS1);
  wire hit_cf = (paddr_i == `RSC_OFF_CONFIG);
  wire hit_ca = (paddr_i == `RSC_OFF_CAUSE);
  wire mapped = hit_s0 | hit_s1 | hit_cf | hit_ca;
  // status flags clear by writing one; a new cause in the same cycle wins
  wire [5:0] clr0 = (wr & hit_s0 & pstrb_i[0]) ? pwdata_i[5:0] : 6'h00;
  wire [9:0] clr1 = (wr & hit_s1) ?
    (pwdata_i[9:0] & {{2{pstrb_i[1]}}, {8{pstrb_i[0]}}}) : 10'h000;

  wire [5:0] set0 = {batt_req, dsby_req, mon_req, in_por};
  wire [9:0] set1 = {cpar_req, sec_req, sp_req, smpu_req, s_bmpu, s_ecc,
    s_par, sw_req, wwdt_rst, independent_watchdog_rst};

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg <= `RSC_CF_RESET;
      status0 <= 6'h00;
      status1 <= 10'h000;
    end else begin
      if (in_por) begin
        cfg <= `RSC_CF_RESET;
      end else if (wr & hit_cf & pstrb_i[0]) begin
        cfg <= pwdata_i[`RSC_CF_W-1:0];
      end
      status0 <= (status0 & ~clr0) | set0;
      if (!s_pin_n && !in_por) begin
        status0[`RSC_S0_POR] <= 1'b0;
      end
      status1 <= (status1 & ~clr1) | set1;
    end
  end

  reg [31:0] rdata;
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata <= 32'h0000_0000;
    end else if (psel_i & ~penable_i & ~pwrite_i) begin
      rdata <= hit_s0 ? {26'h0, status0} :
        hit_s1 ? {22'h0, status1} :
        hit_cf ? {26'h0, cfg} :
        hit_ca ? {29'h0, state} : 32'h0000_0000;
    end
  end
  assign prdata_o = rdata;
  assign pready_o = 1'b1;
  assign pslverr_o = acc & ~mapped;
endmodule // rsc_ctrl
`default_nettype wire

// >>> rsc_partner.sv
// reset pin driver and supply comparators derived from one supply level
`timescale 1ns/1ps
`default_nettype none
module rsc_partner #(
  parameter int POR_MV = 1600,
  parameter int BATT_MV = 1900,
  parameter int MON0_MV = 2800
) (
  input wire logic clk_i,
  input wire logic pin_low_i,
  input wire logic [15:0] vcc_mv_i,
  output var logic ext_reset_pin_n_o,
  output var logic supply_above_por_o,
  output var logic supply_below_batt_o,
  output var logic [2:0] supply_below_mon_o
);
  // monitor levels sit 200 mv apart so one step can trip only the first
  always @(posedge clk_i) begin
    ext_reset_pin_n_o <= !pin_low_i;
    supply_above_por_o <= vcc_mv_i > POR_MV;
    supply_below_batt_o <= vcc_mv_i < BATT_MV;
    supply_below_mon_o <= {vcc_mv_i < MON0_MV - 400,
      vcc_mv_i < MON0_MV - 200, vcc_mv_i < MON0_MV};
  end
endmodule // rsc_partner
`default_nettype wire

// >>> rsc_ctrl_checker.sv
// port assertions for the reset source controller
`timescale 1ns/1ps
`default_nettype none
module rsc_ctrl_checker (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [11:0] paddr_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic ext_reset_pin_n_i,
  input wire logic supply_above_por_i,
  input wire logic supply_below_batt_i,
  input wire logic core_sys_reset_request_i,
  input wire logic internal_reset_n_o,
  input wire logic backup_on_battery_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  pin_hold_a: assert property (!ext_reset_pin_n_i [*4] |->
    !internal_reset_n_o) else $error("reset not held by pin");
  por_hold_a: assert property (!supply_above_por_i [*5] |->
    !internal_reset_n_o) else $error("reset not held by low supply");
  sync_release_a: assert property ($rose(internal_reset_n_o) |->
    $past(ext_reset_pin_n_i, 3) && $past(supply_above_por_i, 3))
    else $error("reset released while a source was active");
  sw_reset_a: assert property ($rose(core_sys_reset_request_i) &&
    internal_reset_n_o && ext_reset_pin_n_i |-> ##[1:5] !internal_reset_n_o)
    else $error("software request gave no reset");
  to_battery_a: assert property (supply_below_batt_i [*4] |->
    backup_on_battery_o) else $error("no switch to battery");
  on_main_a: assert property (!supply_below_batt_i [*4] |->
    !backup_on_battery_o) else $error("battery kept without drop");
  no_wait_a: assert property (psel_i && penable_i |-> pready_o)
    else $error("wait state inserted");
  unmapped_err_a: assert property (psel_i && penable_i &&
    paddr_i >= 12'h010 |-> pslverr_o) else $error("unmapped not refused");
  mapped_ok_a: assert property (psel_i && penable_i && paddr_i <= 12'h00c
    && paddr_i[1:0] == 2'h0 |-> !pslverr_o) else $error("mapped refused");
endmodule // rsc_ctrl_checker
`default_nettype wire

// >>> rsc_ctrl_tb.sv
// self-checking bench for the reset source controller
`timescale 1ns/1ps
`include "rsc_regs.vh"
`default_nettype none
module rsc_ctrl_tb;
  typedef struct {logic w; logic [11:0] a; logic [31:0] d, x; logic e;}
    rsc_row_t;
  rsc_row_t rows[7] = '{'{0, 12'h000, 0, 1, 0}, '{0, 12'h004, 0, 0, 0},
    '{0, 12'h008, 0, 0, 0}, '{0, 12'h00c, 0, 4, 0},
    '{1, 12'h008, 32'h21, 0, 0}, '{1, 12'h010, 32'hff, 0, 1},
    '{0, 12'h010, 0, 0, 1}};
  int bitpos[9] = '{`RSC_S1_INDEPENDENT_WATCHDOG, `RSC_S1_INDEPENDENT_WATCHDOG, `RSC_S1_WWDT, `RSC_S1_WWDT,
    `RSC_S1_PAR, `RSC_S1_ECC, `RSC_S1_BMPU, `RSC_S1_SMPU, `RSC_S1_SP};
  logic clk_i = 0, arst_n_i = 0, psel = 0, pen = 0, pwr = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, pin_n, above_por, below_batt, int_rst_n, nmi;
  logic on_batt, swreq = 0, pin_low = 0;
  logic [2:0] below_mon;
  logic [8:0] ev = '0;
  logic [15:0] vcc = '0;
  int failures = 0, cmp_count = 0;
  always #2.5 clk_i = ~clk_i;
  rsc_partner rsc_partner_inst (.clk_i(clk_i), .pin_low_i(pin_low),
    .vcc_mv_i(vcc), .ext_reset_pin_n_o(pin_n),
    .supply_above_por_o(above_por), .supply_below_batt_o(below_batt),
    .supply_below_mon_o(below_mon));
  rsc_ctrl #(.POR_CYC(20)) rsc_ctrl_inst (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
    .pwdata_i(pwdata), .pstrb_i(4'hf), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .ext_reset_pin_n_i(pin_n),
    .supply_above_por_i(above_por), .supply_below_batt_i(below_batt),
    .supply_below_mon_i(below_mon), .indep_watchdog_underflow_i(ev[0]),
    .indep_watchdog_refresh_miss_i(ev[1]),
    .window_watchdog_underflow_i(ev[2]),
    .window_watchdog_refresh_miss_i(ev[3]), .sram_parity_err_i(ev[4]),
    .sram_ecc_err_i(ev[5]), .master_prot_err_i(ev[6]),
    .slave_prot_err_i(ev[7]), .stack_ptr_err_i(ev[8]),
    .security_err_i(1'b0), .cache_parity_err_i(1'b0),
    .deep_standby_wake_i(1'b0), .core_sys_reset_request_i(swreq),
    .internal_reset_n_o(int_rst_n), .nmi_o(nmi),
    .backup_on_battery_o(on_batt));
  task automatic chk(input string nm, input logic [31:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // called just after an edge; one idle cycle follows each transfer
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    psel <= 1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    pen <= 1;
    do @(posedge clk_i); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    pen <= 0;
    @(posedge clk_i);
  endtask
  task automatic wait_rst(input logic lvl, input int lim);
    int n;
    n = 0;
    while (int_rst_n !== lvl && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    chk("internal_reset_n", lvl, int_rst_n);
  endtask
  task automatic final_report;
    if (failures == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    final_report;
  end
  initial begin
    logic [31:0] r;
    logic e;
    int n;
    repeat (8) @(posedge clk_i);
    arst_n_i <= 1;
    repeat (4) @(posedge clk_i);
    chk("por_hold", 0, int_rst_n);
    vcc <= 16'd3300;
    wait_rst(1, 200);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d, r, e);
      if (!rows[i].w) chk("prdata", rows[i].x, r);
      chk("pslverr", rows[i].e, e);
    end
    pin_low <= 1;
    wait_rst(0, 10);
    repeat (30) @(posedge clk_i);
    chk("pin_held", 0, int_rst_n);
    pin_low <= 0;
    wait_rst(1, 200);
    apb(0, 12'h000, 0, r, e);
    chk("por_flag", 0, r[0]);
    foreach (bitpos[i]) begin
      ev[i] <= 1;
      repeat (2) @(posedge clk_i);
      ev[i] <= 0;
      wait_rst(0, 10);
      wait_rst(1, 2200);
      apb(0, 12'h004, 0, r, e);
      chk("status1", 32'h1 << bitpos[i], r);
      apb(1, 12'h004, r, r, e);
    end
    swreq <= 1;
    wait_rst(0, 10);
    swreq <= 0;
    wait_rst(1, 200);
    apb(0, 12'h004, 0, r, e);
    chk("sw_flag", 32'h1 << `RSC_S1_SW, r);
    apb(1, 12'h008, 32'h1 << `RSC_CF_INDEPENDENT_WATCHDOG_NMI, r, e);
    ev[0] <= 1;
    for (n = 0; n < 10 && nmi !== 1'b1; n++) @(posedge clk_i);
    chk("nmi", 1, nmi);
    chk("no_reset", 1, int_rst_n);
    ev[0] <= 0;
    apb(1, 12'h008, 32'h21, r, e);
    vcc <= 16'd2700;
    wait_rst(0, 10);
    vcc <= 16'd3300;
    wait_rst(1, 2200);
    apb(0, 12'h000, 0, r, e);
    chk("mon0_flag", 32'h1 << `RSC_S0_MON0, r);
    vcc <= 16'd1800;
    repeat (6) @(posedge clk_i);
    chk("on_battery", 1, on_batt);
    vcc <= 16'd1500;
    repeat (6) @(posedge clk_i);
    chk("por_again", 0, int_rst_n);
    vcc <= 16'd3300;
    wait_rst(1, 2200);
    apb(0, 12'h000, 0, r, e);
    chk("por_flag_set", 1, r[0]);
    chk("batt_flag", 1, r[`RSC_S0_BATT]);
    final_report;
  end
endmodule // rsc_ctrl_tb
bind rsc_ctrl rsc_ctrl_checker rsc_ctrl_checker_inst (.clk_i(clk_i),
  .arst_n_i(arst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .paddr_i(paddr_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .ext_reset_pin_n_i(ext_reset_pin_n_i),
  .supply_above_por_i(supply_above_por_i),
  .supply_below_batt_i(supply_below_batt_i),
  .core_sys_reset_request_i(core_sys_reset_request_i),
  .internal_reset_n_o(internal_reset_n_o),
  .backup_on_battery_o(backup_on_battery_o));
`default_nettype wire
